// File: inc/pcg_regs.svh
// Purpose: Offsets, field positions, strap presets and timing counts of the clock mode block
// Assumes: Included by its bare name from the package and the design
// Notes:   Definitions only
`ifndef PCG_REGS_SVH
`define PCG_REGS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define PCG_MODE_ADDR 16'h0058

// ----------------------------------------------------------------------
// Field positions of clock_generation_mode
// ----------------------------------------------------------------------
`define PCG_MUL_HI 15
`define PCG_MUL_LO 12
`define PCG_DIV_BIT 11
`define PCG_CNT_HI 10
`define PCG_CNT_LO 3
`define PCG_ON_BIT 2
`define PCG_NDIV_BIT 1
`define PCG_STAT_BIT 0
`define PCG_MUL_DIV4 4'hF

// ----------------------------------------------------------------------
// Reset values chosen by the straps {a,b,c}
// ----------------------------------------------------------------------
`define PCG_RST_000 16'h0000
`define PCG_RST_001 16'h9007
`define PCG_RST_010 16'h4007
`define PCG_RST_100 16'h1007
`define PCG_RST_110 16'hF007
`define PCG_RST_111 16'h0000
`define PCG_RST_101 16'hF000
`define PCG_RST_011 16'h0000

// ----------------------------------------------------------------------
// Lock timer: each count unit lasts 2**shift clocks
// ----------------------------------------------------------------------
`define PCG_LOCK_SHIFT 4
`define PCG_CNT_W 12

`endif

// File: inc/pcg_pkg.sv
// Purpose: Types of the clock mode block
// Assumes: pcg_regs.svh holds all numbers
// Notes:   Used as pcg_pkg::name, never imported
`include "pcg_regs.svh"

package pcg_pkg;

   // PLL clocking state
   typedef enum logic [1:0] {
      PCG_OFF  = 2'b00,
      PCG_ACQ  = 2'b01,
      PCG_LOCK = 2'b10
   } pcg_state_e;

   // Whole state of the block
   typedef struct packed {
      logic [15:1] mode;
      pcg_state_e st;
      logic [`PCG_CNT_W-1:0] cnt;
      logic [15:0] rdata;
      logic rvalid;
      logic osc_en;
   } pcg_state_s;

endpackage

// File: verilog/pcg_clock_mode.sv
// Purpose: Clock mode register, lock timer and clock source selection for the master clock
// Assumes: All inputs synchronous to clk_i; memory-mapped word access at one address
// Notes:   Drives control of the divider and PLL; the analog loop itself lies outside
`timescale 1ns/1ps
`include "pcg_regs.svh"

// What this block does
// - Divider mode divides the reference clock by 2 or by 4.
// - PLL mode multiplies the reference by one of 31 ratios.
// - PLL start with a nonzero lock count passes an acquisition phase, then stays locked and tracking.
// - Lock timer holds off switching to PLL clocking until expected lock.
// - In divider mode software may power the PLL off completely.
// - Configuration lives in a 16-bit register at address 0058h.
// - Reset value of the register depends only on the three straps.
// - Straps 000 give 0000h, PLL and oscillator off.
// - Straps 001 give 9007h, PLL times ten, oscillator on.
// - Straps 010 give 4007h, PLL times five, oscillator on.
// - Straps 100 give 1007h, PLL times two, oscillator on.
// - Straps 110 give F007h, PLL times one, oscillator on.
// - Straps 111 give 0000h, divider mode, oscillator on.
// - Straps 101 give F000h, divide by four, oscillator on.
// - Straps choose the mode only while reset is held low.
// - After reset a software write changes the clock mode.
// - Oscillator enable follows the straps always; later strap changes touch nothing else.
module pcg_clock_mode (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic mode_strap_pin_a_i,
   input wire logic mode_strap_pin_b_i,
   input wire logic mode_strap_pin_c_i,
   input wire logic [15:0] addr_i,
   input wire logic wr_i,
   input wire logic [15:0] wdata_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   output logic rvalid_o,
   output logic osc_enable_o,
   output logic pll_power_on_o,
   output logic [3:0] pll_mult_o,
   output logic pll_div_o,
   output logic div_by4_o,
   output logic pll_clock_sel_o,
   output logic pll_acquiring_o
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   pcg_pkg::pcg_state_s st_reg;
   pcg_pkg::pcg_state_s st_next;
   pcg_pkg::pcg_state_s st_rst;
   logic [2:0] strap;
   logic [15:0] preset;
   logic [15:0] readback;
   logic wr_hit;
   logic [`PCG_CNT_W-1:0] cnt_load;

   assign strap = {mode_strap_pin_a_i, mode_strap_pin_b_i, mode_strap_pin_c_i};

   // Strap decode; 011 is bypass with no defined value, so the safe /2 is used
   always_comb begin
      preset = `PCG_RST_011;
      case (strap)
         3'h0: preset = `PCG_RST_000;
         3'h1: preset = `PCG_RST_001;
         3'h2: preset = `PCG_RST_010;
         3'h4: preset = `PCG_RST_100;
         3'h6: preset = `PCG_RST_110;
         3'h7: preset = `PCG_RST_111;
         3'h5: preset = `PCG_RST_101;
         default: preset = `PCG_RST_011;
      endcase
   end

   // State loaded during reset: presets carry a zero lock count, so PLL
   // presets start locked and the status bit reads back as printed
   always_comb begin
      st_rst = '0;
      st_rst.mode = preset[15:1];
      st_rst.st = preset[`PCG_NDIV_BIT] ? pcg_pkg::PCG_LOCK : pcg_pkg::PCG_OFF;
      st_rst.osc_en = (strap != 3'h0);
   end

   // ----------------------------------------------------------------------
   // Register access and lock timer
   // ----------------------------------------------------------------------
   assign wr_hit = wr_i && (addr_i == `PCG_MODE_ADDR);
   assign cnt_load = `PCG_CNT_W'({4'h0, wdata_i[`PCG_CNT_HI:`PCG_CNT_LO]} << `PCG_LOCK_SHIFT);
   assign readback = {st_reg.mode, st_reg.st == pcg_pkg::PCG_LOCK};

   // Next-state logic for the whole block
   always_comb begin
      st_next = st_reg;
      st_next.rvalid = 1'b0;
      // Straps keep steering the oscillator after reset, nothing else
      st_next.osc_en = (strap != 3'h0);
      if (rd_i) begin
         st_next.rvalid = 1'b1;
         if (addr_i == `PCG_MODE_ADDR) begin
            st_next.rdata = readback;
         end else begin
            st_next.rdata = 16'h0000;
         end
      end
      if (wr_hit) begin
         st_next.mode = wdata_i[15:1];
         if (wdata_i[`PCG_NDIV_BIT]) begin
            // Every PLL write restarts acquisition; a zero count switches at once
            st_next.cnt = cnt_load;
            if (cnt_load == '0) begin
               st_next.st = pcg_pkg::PCG_LOCK;
            end else begin
               st_next.st = pcg_pkg::PCG_ACQ;
            end
         end else begin
            st_next.st = pcg_pkg::PCG_OFF;
            st_next.cnt = '0;
         end
      end else begin
         case (st_reg.st)
            pcg_pkg::PCG_ACQ: begin
               // Hold off PLL clocking until the timer runs out
               st_next.cnt = st_reg.cnt - `PCG_CNT_W'(1);
               if (st_reg.cnt == `PCG_CNT_W'(1)) begin
                  st_next.st = pcg_pkg::PCG_LOCK;
               end
            end
            pcg_pkg::PCG_LOCK: begin
               st_next.st = pcg_pkg::PCG_LOCK;
            end
            default: begin
               st_next.st = pcg_pkg::PCG_OFF;
            end
         endcase
      end
   end

   // Synchronous reset keeps loading the strap preset while reset is low
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         st_reg <= st_rst;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   // All controls decode registered state, so they are glitch free
   assign rdata_o = st_reg.rdata;
   assign rvalid_o = st_reg.rvalid;
   assign osc_enable_o = st_reg.osc_en;
   // PLL runs in PLL mode, or in divider mode only if left switched on
   assign pll_power_on_o = st_reg.mode[`PCG_NDIV_BIT] | st_reg.mode[`PCG_ON_BIT];
   assign pll_mult_o = st_reg.mode[`PCG_MUL_HI:`PCG_MUL_LO];
   assign pll_div_o = st_reg.mode[`PCG_DIV_BIT];
   assign div_by4_o = ~st_reg.mode[`PCG_NDIV_BIT] &
                      (st_reg.mode[`PCG_MUL_HI:`PCG_MUL_LO] == `PCG_MUL_DIV4);
   assign pll_clock_sel_o = (st_reg.st == pcg_pkg::PCG_LOCK);
   assign pll_acquiring_o = (st_reg.st == pcg_pkg::PCG_ACQ);

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   property p_div_mode;
      wr_hit && !wdata_i[`PCG_NDIV_BIT] |=>
         !pll_clock_sel_o && (div_by4_o == ($past(wdata_i[15:12]) == 4'hF));
   endproperty
   a_div_mode: assert property (p_div_mode) else $error("divider select wrong");

   property p_ratio;
      wr_hit |=> pll_mult_o == $past(wdata_i[15:12]) && pll_div_o == $past(wdata_i[11]);
   endproperty
   a_ratio: assert property (p_ratio) else $error("ratio not taken");

   property p_acquire;
      wr_hit && wdata_i[1] && (wdata_i[10:3] != 8'h00) |=>
         pll_acquiring_o && !pll_clock_sel_o;
   endproperty
   a_acquire: assert property (p_acquire) else $error("no acquisition phase");

   property p_lock_end;
      !wr_hit && pll_acquiring_o && (st_reg.cnt == 12'h001) |=> pll_clock_sel_o;
   endproperty
   a_lock_end: assert property (p_lock_end) else $error("lock timer end missed");

   property p_hold_off;
      wr_hit && wdata_i[1] && (wdata_i[10:3] == 8'h01) ##1 !wr_hit [*8] |=>
         !pll_clock_sel_o;
   endproperty
   a_hold_off: assert property (p_hold_off) else $error("switched before timer");

   property p_power_off;
      wr_hit && !wdata_i[1] && !wdata_i[2] |=> !pll_power_on_o;
   endproperty
   a_power_off: assert property (p_power_off) else $error("PLL not powered off");

   property p_readback;
      rd_i && (addr_i == 16'h0058) |=> rvalid_o && rdata_o == $past(readback);
   endproperty
   a_readback: assert property (p_readback) else $error("read data wrong");

   property p_reset_val;
      @(posedge clk_i) $rose(rstn_i) && $past(strap) == 3'h1 |->
         readback == 16'h9007;
   endproperty
   a_reset_val: assert property (p_reset_val) else $error("preset 001 wrong");

   property p_osc;
      ##1 osc_enable_o == ($past(strap) != 3'h0);
   endproperty
   a_osc: assert property (p_osc) else $error("oscillator enable not following straps");

   property p_strap_late;
      !wr_hit && !pll_acquiring_o |=> $stable(st_reg.mode);
   endproperty
   a_strap_late: assert property (p_strap_late) else $error("mode changed without write");

   // ----------------------------------------------------------------------
   // Strap presets, seen at the first edge after release
   // ----------------------------------------------------------------------
   // Straps freeze into the mode only while reset is low, so the value
   // loaded at the last reset edge is the one that must read back
   property p_preset_000;
      @(posedge clk_i) $rose(rstn_i) && $past(strap) == 3'h0 |->
         readback == 16'h0000 && !osc_enable_o;
   endproperty
   a_preset_000: assert property (p_preset_000) else $error("preset 000 wrong");

   property p_preset_010;
      @(posedge clk_i) $rose(rstn_i) && $past(strap) == 3'h2 |->
         readback == 16'h4007 && osc_enable_o;
   endproperty
   a_preset_010: assert property (p_preset_010) else $error("preset 010 wrong");

   property p_preset_100;
      @(posedge clk_i) $rose(rstn_i) && $past(strap) == 3'h4 |->
         readback == 16'h1007 && osc_enable_o;
   endproperty
   a_preset_100: assert property (p_preset_100) else $error("preset 100 wrong");

   property p_preset_110;
      @(posedge clk_i) $rose(rstn_i) && $past(strap) == 3'h6 |->
         readback == 16'hF007 && osc_enable_o;
   endproperty
   a_preset_110: assert property (p_preset_110) else $error("preset 110 wrong");

   property p_preset_111;
      @(posedge clk_i) $rose(rstn_i) && $past(strap) == 3'h7 |->
         readback == 16'h0000 && osc_enable_o;
   endproperty
   a_preset_111: assert property (p_preset_111) else $error("preset 111 wrong");

   property p_preset_101;
      @(posedge clk_i) $rose(rstn_i) && $past(strap) == 3'h5 |->
         readback == 16'hF000 && osc_enable_o;
   endproperty
   a_preset_101: assert property (p_preset_101) else $error("preset 101 wrong");

   // ----------------------------------------------------------------------
   // Register writes and reads
   // ----------------------------------------------------------------------
   // Whole mode word comes from the write; the status bit is not stored
   property p_write_mode;
      wr_hit |=> st_reg.mode == $past(wdata_i[15:1]);
   endproperty
   a_write_mode: assert property (p_write_mode) else $error("mode not written");

   // A strobe at a neighbouring address must leave the mode alone
   property p_wr_miss;
      wr_i && !wr_hit |=> $stable(st_reg.mode);
   endproperty
   a_wr_miss: assert property (p_wr_miss) else $error("unmapped write changed mode");

   property p_rd_miss;
      rd_i && (addr_i != 16'h0058) |=> rvalid_o && rdata_o == 16'h0000;
   endproperty
   a_rd_miss: assert property (p_rd_miss) else $error("unmapped read not zero");

   // ----------------------------------------------------------------------
   // Lock timer and PLL power
   // ----------------------------------------------------------------------
   // Timer drops by one each clock while it runs, never skips
   property p_acq_count;
      pll_acquiring_o && !wr_hit |=> st_reg.cnt == $past(st_reg.cnt) - 12'h001;
   endproperty
   a_acq_count: assert property (p_acq_count) else $error("lock timer skipped");

   // Once locked, clocking stays on the PLL until software changes mode
   property p_pll_run;
      pll_clock_sel_o && !wr_hit |=> pll_clock_sel_o;
   endproperty
   a_pll_run: assert property (p_pll_run) else $error("PLL clocking dropped");

   // Divider mode may leave the PLL powered, but never clocks from it
   property p_leave_pll;
      wr_hit && !wdata_i[1] && wdata_i[2] |=>
         pll_power_on_o && !pll_clock_sel_o && !pll_acquiring_o;
   endproperty
   a_leave_pll: assert property (p_leave_pll) else $error("divider mode left PLL clocking");

   c_lock: cover property (pll_acquiring_o ##1 pll_clock_sel_o);
   c_div4: cover property (wr_hit ##1 div_by4_o);
   c_read: cover property (rvalid_o && rdata_o[0]);
   c_restart: cover property (pll_acquiring_o && wr_hit && wdata_i[1]);

endmodule // pcg_clock_mode

// File: test/pcg_strap_src.sv
// Purpose: Strap pin source outside the clock mode block
// Assumes: Bench holds the code steady while reset is low
// Notes:   Reserved code 011 is never presented
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Strap source
// ----------------------------------------------------------------------
module pcg_strap_src (
   input wire logic [2:0] code_i,
   output logic strap_a_o,
   output logic strap_b_o,
   output logic strap_c_o
);
   // Bypass code swapped for 111, so no undefined preset is ever loaded
   always_comb begin
      {strap_a_o, strap_b_o, strap_c_o} = (code_i == 3'h3) ? 3'h7 : code_i;
   end
endmodule // pcg_strap_src

// File: test/tb_top.sv
// Purpose: Self-checking bench of the clock mode block
// Assumes: Inputs change at the falling edge; seed fixed at 57
// Notes:   Strap presets, register access, lock timer and late strap moves
`timescale 1ns/1ps
`include "pcg_regs.svh"

module tb_top;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [2:0] code = 3'h0;
   logic sa;
   logic sb;
   logic sc;
   logic [15:0] addr_i = 16'h0000;
   logic wr_i = 1'b0;
   logic [15:0] wdata_i = 16'h0000;
   logic rd_i = 1'b0;
   logic [15:0] rdata_o;
   logic rvalid_o, osc_enable_o, pll_power_on_o, pll_div_o;
   logic div_by4_o, pll_clock_sel_o, pll_acquiring_o;
   logic [3:0] pll_mult_o;
   integer seed = 57;
   integer fails = 0;
   integer total_checks = 0;
   integer i;
   integer n;
   logic [15:0] w;
   logic [15:0] v;

   // ----------------------------------------------------------------------
   // Design and strap source
   // ----------------------------------------------------------------------
   pcg_strap_src u_straps (.code_i(code), .strap_a_o(sa), .strap_b_o(sb), .strap_c_o(sc));
   pcg_clock_mode u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .mode_strap_pin_a_i(sa),
      .mode_strap_pin_b_i(sb), .mode_strap_pin_c_i(sc), .addr_i(addr_i), .wr_i(wr_i),
      .wdata_i(wdata_i), .rd_i(rd_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
      .osc_enable_o(osc_enable_o), .pll_power_on_o(pll_power_on_o), .pll_mult_o(pll_mult_o),
      .pll_div_o(pll_div_o), .div_by4_o(div_by4_o), .pll_clock_sel_o(pll_clock_sel_o),
      .pll_acquiring_o(pll_acquiring_o));

   // 4 ns clock
   initial begin
      forever #2 clk_i = ~clk_i;
   end

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wrap_up;
      if (fails == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // Preset per strap code {a,b,c}
   function automatic logic [15:0] preset(input logic [2:0] c);
      case (c)
         3'h1: preset = 16'h9007;
         3'h2: preset = 16'h4007;
         3'h4: preset = 16'h1007;
         3'h6: preset = 16'hF007;
         3'h5: preset = 16'hF000;
         default: preset = 16'h0000;
      endcase
   endfunction

   // Straps change at the same falling edge as reset and stay put until release
   task automatic do_rst(input logic [2:0] c);
      @(negedge clk_i);
      code = c;
      rstn_i = 1'b0;
      repeat (6) @(negedge clk_i);
      rstn_i = 1'b1;
   endtask

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(negedge clk_i);
      addr_i = a;
      wdata_i = d;
      wr_i = 1'b1;
      @(negedge clk_i);
      wr_i = 1'b0;
   endtask

   // Answer is looked at in the cycle after the taking edge
   task automatic rd(input logic [15:0] a);
      @(negedge clk_i);
      addr_i = a;
      rd_i = 1'b1;
      @(negedge clk_i);
      rd_i = 1'b0;
      chk("rvalid", rvalid_o, 16'h0001);
   endtask

   // Bounded wait for the switch to PLL clocking
   task automatic wait_lock(output integer k);
      k = 0;
      while (pll_clock_sel_o !== 1'b1 && k < 5000) begin
         @(negedge clk_i);
         k++;
      end
      if (k == 5000) begin
         chk("lock_wait", 16'h0000, 16'h0001);
         wrap_up();
      end
   endtask

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      // Every legal strap code, then a strap move after release
      for (i = 0; i < 8; i++) begin
         if (i != 3) begin
            do_rst(i[2:0]);
            v = preset(i[2:0]);
            chk("osc", osc_enable_o, 16'(i != 0));
            chk("sel", pll_clock_sel_o, v[1]);
            chk("mult", pll_mult_o, v[15:12]);
            chk("pwr", pll_power_on_o, v[1] | v[2]);
            chk("div4", div_by4_o, !v[1] && v[15:12] == 4'hF);
            rd(`PCG_MODE_ADDR);
            chk("preset", rdata_o, v);
            code = (i == 0) ? 3'h7 : 3'h0;
            repeat (2) @(negedge clk_i);
            chk("osc_late", osc_enable_o, 16'(i == 0));
            rd(`PCG_MODE_ADDR);
            chk("kept", rdata_o, v);
         end
      end
      // Corner values first, then random ones with short lock counts
      for (i = 0; i < 12; i++) begin
         w = 16'($random(seed));
         w[10:5] = 6'h00;
         if (i == 0) w = 16'hF000;
         if (i == 1) w = 16'hFFFF;
         if (i == 2) w = 16'h0004;
         wr(`PCG_MODE_ADDR, w);
         chk("mult_w", pll_mult_o, w[15:12]);
         chk("div_w", pll_div_o, w[11]);
         chk("pwr_w", pll_power_on_o, w[1] | w[2]);
         if (w[1]) begin
            if (w[10:3] != 8'h00) chk("acq", pll_acquiring_o, 16'h0001);
            wait_lock(n);
            chk("lock", n[15:0], 16'(w[10:3]) << `PCG_LOCK_SHIFT);
            chk("acq_end", pll_acquiring_o, 16'h0000);
         end else begin
            chk("sel_off", pll_clock_sel_o, 16'h0000);
            chk("div4_w", div_by4_o, w[15:12] == 4'hF);
         end
         rd(`PCG_MODE_ADDR);
         chk("rback", rdata_o, {w[15:1], w[1]});
      end
      // Rewrite during acquisition restarts the timer with the new count
      wr(`PCG_MODE_ADDR, 16'h901A);
      chk("acq_r", pll_acquiring_o, 16'h0001);
      w = 16'h500A;
      wr(`PCG_MODE_ADDR, w);
      chk("acq_r2", pll_acquiring_o, 16'h0001);
      wait_lock(n);
      chk("relock", n[15:0], 16'h0001 << `PCG_LOCK_SHIFT);
      // Neighbouring addresses are not the register
      wr(16'h0057, 16'h1234);
      rd(`PCG_MODE_ADDR);
      chk("unmapped_wr", rdata_o, {w[15:1], w[1]});
      rd(16'h0059);
      chk("unmapped_rd", rdata_o, 16'h0000);
      wrap_up();
   end
endmodule // tb_top
